/* File: core/gpio_irq_status_mask_edge.sv */
// GPIO pin muxing, pin events, status, mask and edge-type registers behind APB
`timescale 1ns/1ps
module gpio_irq_status_mask_edge
  import gpio_irq_pkg::*;
#(
  parameter int unsigned NP = gpio_irq_pkg::NPINS
) (
  input wire logic CLK, // System clock, 125 MHz
  input wire logic RST_B, // Asynchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB write
  input wire logic [gpio_irq_pkg::ADDR_W-1:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  input wire logic [3:0] PSTRB, // APB byte strobes
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic [NP-1:0] PIN_IN, // Pin levels from pads
  output logic [NP-1:0] PIN_OUT, // Pin drive levels
  output logic [NP-1:0] PIN_OE_B, // Pin drive enable, active low
  input wire logic [NP-1:0] ALT_OUT, // Pin-specific function levels
  input wire logic [NP-1:0] ALT_OE, // Pin-specific function drive enables
  input wire logic [gpio_irq_pkg::NFUNC_SRC-1:0] FUNC_SRC, // Shared output sources
  input wire logic [1:0] DSP_IRQ, // DSP interrupt lines zero and one
  input wire logic EVENT_LOG_FULL, // Event log FIFO full
  input wire logic BOOT_DONE, // Boot sequence complete
  output logic IRQ // Interrupt, active high level
);
  import gpio_irq_pkg::*;

  typedef struct packed {
    logic [31:0] evt;
    logic [31:0] mask;
    logic [31:0] edge_sel;
    logic [NP-1:0][3:0] fn;
    logic [NP-1:0] out_lvl;
    logic [NP-1:0] open_drain;
    logic [NP-1:0] db_en;
    logic [NP-1:0][1:0] db_hist;
    logic [NP-1:0] level;
    logic [NP-1:0] level_prev;
    logic [1:0] dsp_prev;
    logic full_prev;
    logic boot_prev;
    logic [15:0] tick_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [NP-1:0] pin_out;
    logic [NP-1:0] pin_oe_b;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [NP-1:0] pin_sync_level;
  logic [NP-1:0] pin_evt;
  logic [NP-1:0] drive_val;
  logic [NP-1:0] drive_en;
  logic [31:0] line_status;
  logic [31:0] wmask;

  pin_sync #(
    .W(NP)
  ) u_pin_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .async_in(PIN_IN),
    .level_out(pin_sync_level)
  );

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_pin
      logic is_in;
      logic rise;
      logic fall;
      logic rise_hit;
      logic fall_hit;
      logic [3:0] src_idx;
      logic src_val;
      assign is_in = (state_reg.fn[g] == FN_GPIO_IN);
      assign rise = state_reg.level[g] & ~state_reg.level_prev[g];
      assign fall = ~state_reg.level[g] & state_reg.level_prev[g];
      if (g < NEDGE_PINS)
      begin : g_typed
        // Edge type fires once; level type re-sets while the level persists
        assign rise_hit = state_reg.edge_sel[EDGE_LSB + 2 * g] ? rise :
          (rise | (state_reg.level[g] & state_reg.level_prev[g]));
        assign fall_hit = state_reg.edge_sel[EDGE_LSB + 2 * g + 1] ? fall :
          (fall | ~(state_reg.level[g] | state_reg.level_prev[g]));
      end
      else
      begin : g_plain
        assign rise_hit = rise;
        assign fall_hit = fall;
      end
      assign pin_evt[g] = is_in & (rise_hit | fall_hit);
      assign src_idx = state_reg.fn[g] - FN_SRC_BASE;
      assign src_val = (src_idx < 4'(NFUNC_SRC)) ? FUNC_SRC[src_idx[2:0]] : 1'b0;
      always_comb
      begin
        drive_val[g] = 1'b0;
        drive_en[g] = 1'b0;
        unique case (state_reg.fn[g])
          FN_ALT:
          begin
            // Dedicated pins have no pin-specific function
            drive_val[g] = (g >= DEDICATED_PINS) ? ALT_OUT[g] : 1'b0;
            drive_en[g] = (g >= DEDICATED_PINS) ? ALT_OE[g] : 1'b0;
          end
          FN_GPIO_IN:
          begin
            // Inputs never drive; the pad level only feeds events and status
            drive_en[g] = 1'b0;
          end
          FN_GPIO_OUT:
          begin
            drive_val[g] = state_reg.out_lvl[g];
            drive_en[g] = 1'b1;
          end
          FN_IRQ:
          begin
            drive_val[g] = state_reg.irq;
            drive_en[g] = 1'b1;
          end
          default:
          begin
            // Codes past the last source leave the pin undriven
            drive_val[g] = src_val;
            drive_en[g] = (state_reg.fn[g] <= FN_DSP_BUSY);
          end
        endcase
      end
    end
  endgenerate

  always_comb
  begin
    line_status = '0;
    line_status[STS_DSP0] = DSP_IRQ[0];
    line_status[STS_DSP1] = DSP_IRQ[1];
    for (int i = 0; i < int'(NEDGE_PINS); i++)
    begin
      // DSP-owned inputs and non-input pins read zero
      line_status[STS_PIN_LSB + 2 * i] = (state_reg.fn[i] == FN_GPIO_IN) &
        state_reg.level[i];
    end
  end

  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[8 * b +: 8] = {8{PSTRB[b]}};
    end
  end

  always_comb
  begin
    logic [31:0] evt_set;
    logic [31:0] evt_clr;
    logic wr_access;
    logic [19:0] addr;
    state_next = state_reg;
    evt_set = '0;
    evt_clr = '0;
    addr = PADDR;
    wr_access = PSEL & PENABLE & state_reg.pready & PWRITE;

    // Debounce: take a new level only after three equal samples
    state_next.tick_cnt = (state_reg.tick_cnt == DB_TICK_LAST) ? 16'h0000 :
      state_reg.tick_cnt + 16'h0001;
    for (int i = 0; i < int'(NP); i++)
    begin
      if (!state_reg.db_en[i])
      begin
        state_next.level[i] = pin_sync_level[i];
        // Stale history would let a re-enabled filter accept too early
        state_next.db_hist[i] = {2{pin_sync_level[i]}};
      end
      else if (state_reg.tick_cnt == DB_TICK_LAST)
      begin
        state_next.db_hist[i] = {state_reg.db_hist[i][0], pin_sync_level[i]};
        if (state_reg.db_hist[i] == {2{pin_sync_level[i]}})
        begin
          state_next.level[i] = pin_sync_level[i];
        end
      end
    end
    state_next.level_prev = state_reg.level;

    // Source events latch on their rising transition
    evt_set[EVT_BOOT] = BOOT_DONE & ~state_reg.boot_prev;
    evt_set[EVT_DSP0] = DSP_IRQ[0] & ~state_reg.dsp_prev[0];
    evt_set[EVT_DSP1] = DSP_IRQ[1] & ~state_reg.dsp_prev[1];
    evt_set[EVT_FULL] = EVENT_LOG_FULL & ~state_reg.full_prev;
    evt_set[EVT_PIN_LSB +: NP] = pin_evt;
    state_next.boot_prev = BOOT_DONE;
    state_next.dsp_prev = DSP_IRQ;
    state_next.full_prev = EVENT_LOG_FULL;

    // Register writes land at the access edge
    if (wr_access)
    begin
      unique case (addr)
        OFF_EVENT:
        begin
          evt_clr = PWDATA & wmask;
        end
        OFF_MASK:
        begin
          state_next.mask = ((PWDATA & wmask) | (state_reg.mask & ~wmask)) &
            EVT_USED;
        end
        OFF_EDGE_SEL:
        begin
          state_next.edge_sel[31:EDGE_LSB] = PWDATA[31:EDGE_LSB] & wmask[31:EDGE_LSB]
            | state_reg.edge_sel[31:EDGE_LSB] & ~wmask[31:EDGE_LSB];
        end
        OFF_FUNC_LO:
        begin
          for (int i = 0; i < 8; i++)
          begin
            if (PSTRB[i / 2])
            begin
              state_next.fn[i] = PWDATA[4 * i +: 4];
            end
          end
        end
        OFF_FUNC_HI:
        begin
          for (int i = 0; i < 8; i++)
          begin
            if (PSTRB[i / 2])
            begin
              state_next.fn[i + 8] = PWDATA[4 * i +: 4];
            end
          end
        end
        OFF_PIN_CFG:
        begin
          state_next.out_lvl = PWDATA[15:0] & wmask[15:0] | state_reg.out_lvl & ~wmask[15:0];
          state_next.open_drain = PWDATA[31:CFG_OD_LSB] & wmask[31:CFG_OD_LSB]
            | state_reg.open_drain & ~wmask[31:CFG_OD_LSB];
        end
        OFF_DEBOUNCE:
        begin
          state_next.db_en = PWDATA[15:0] & wmask[15:0] | state_reg.db_en & ~wmask[15:0];
        end
        OFF_LINE_STATUS, OFF_FULL_STATUS:
        begin
          // Status words are read-only; writes pass without an error
          evt_clr = '0;
        end
        default:
        begin
          evt_clr = '0;
        end
      endcase
    end
    // A new event in the clearing cycle survives the clear
    state_next.evt = ((state_reg.evt & ~evt_clr) | evt_set) & EVT_USED;
    state_next.irq = |(state_reg.evt & ~state_reg.mask);

    // Zero-wait APB: data prepared in setup, answered in access
    state_next.pready = PSEL & ~PENABLE;
    state_next.pslverr = 1'b0;
    state_next.prdata = '0;
    if (PSEL & ~PENABLE)
    begin
      unique case (addr)
        OFF_EVENT: state_next.prdata = state_reg.evt;
        OFF_MASK: state_next.prdata = state_reg.mask;
        OFF_LINE_STATUS: state_next.prdata = line_status;
        OFF_FULL_STATUS: state_next.prdata[STS_FULL] = EVENT_LOG_FULL;
        OFF_EDGE_SEL: state_next.prdata = state_reg.edge_sel;
        OFF_FUNC_LO: state_next.prdata = state_reg.fn[7:0];
        OFF_FUNC_HI: state_next.prdata = state_reg.fn[15:8];
        OFF_PIN_CFG: state_next.prdata = {state_reg.open_drain, state_reg.out_lvl};
        OFF_DEBOUNCE: state_next.prdata = {16'h0000, state_reg.db_en};
        default: state_next.pslverr = 1'b1;
      endcase
      // Writes answer with zero data so no register leaks onto the bus
      if (PWRITE)
      begin
        state_next.prdata = '0;
      end
    end

    // Open drain drives only a low level
    for (int i = 0; i < int'(NP); i++)
    begin
      state_next.pin_out[i] = drive_val[i];
      state_next.pin_oe_b[i] = ~(drive_en[i] & ~(state_reg.open_drain[i] & drive_val[i]));
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= '0;
      state_reg.mask <= MASK_RESET & EVT_USED;
      state_reg.edge_sel <= EDGE_SEL_RESET;
      // All pins start as inputs so nothing drives before software sets up
      state_reg.fn <= {NP{FN_RESET}};
      state_reg.pin_oe_b <= '1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign PRDATA = state_reg.prdata;
  assign PREADY = state_reg.pready;
  assign PSLVERR = state_reg.pslverr;
  assign PIN_OUT = state_reg.pin_out;
  assign PIN_OE_B = state_reg.pin_oe_b;
  assign IRQ = state_reg.irq;
endmodule

/* File: core/pin_sync.sv */
// Three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 16
) (
  input wire logic CLK, // System clock
  input wire logic RST_B, // Asynchronous reset, active low
  input wire logic [W-1:0] async_in, // Pin levels from outside
  output logic [W-1:0] level_out // Accepted level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < int'(W); i++)
    begin
      if (state_reg.s2[i] == state_reg.s3[i])
      begin
        state_next.level[i] = state_reg.s3[i];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.level;
endmodule

/* File: shared/gpio_irq_pkg.sv */
// Register map, field layout and timing constants of the GPIO interrupt block
package gpio_irq_pkg;
  localparam int unsigned NPINS = 16;
  localparam int unsigned NEDGE_PINS = 8;
  localparam int unsigned NFUNC_SRC = 8;
  localparam int unsigned ADDR_W = 20;
  localparam logic [19:0] OFF_EVENT = 20'h18010;
  localparam logic [19:0] OFF_LINE_STATUS = 20'h180b8;
  localparam logic [19:0] OFF_FULL_STATUS = 20'h180bc;
  localparam logic [19:0] MASK_STRIDE = 20'h00100;
  localparam logic [19:0] OFF_MASK = 20'h18110;
  localparam logic [19:0] OFF_EDGE_SEL = 20'h18238;
  localparam logic [19:0] OFF_FUNC_LO = 20'h18300;
  localparam logic [19:0] OFF_FUNC_HI = 20'h18304;
  localparam logic [19:0] OFF_PIN_CFG = 20'h18308;
  localparam logic [19:0] OFF_DEBOUNCE = 20'h1830c;
  // Event register bit positions
  localparam int unsigned EVT_BOOT = 0;
  localparam int unsigned EVT_DSP0 = 1;
  localparam int unsigned EVT_DSP1 = 2;
  localparam int unsigned EVT_FULL = 3;
  localparam int unsigned EVT_PIN_LSB = 16;
  localparam logic [31:0] EVT_USED = 32'hffff_000f;
  localparam logic [31:0] MASK_RESET = 32'hffff_fffe;
  localparam logic [31:0] EDGE_SEL_RESET = 32'h0000_0000;
  // Status field positions
  localparam int unsigned STS_DSP0 = 0;
  localparam int unsigned STS_DSP1 = 1;
  localparam int unsigned STS_PIN_LSB = 16;
  localparam int unsigned STS_FULL = 16;
  localparam int unsigned EDGE_LSB = 16;
  localparam int unsigned CFG_OD_LSB = 16;
  localparam int unsigned DEDICATED_PINS = 2;
  // Pin function codes
  typedef enum logic [3:0] {
    FN_ALT = 4'h0,
    FN_GPIO_IN = 4'h1,
    FN_GPIO_OUT = 4'h2,
    FN_IRQ = 4'h3,
    FN_CLK = 4'h4,
    FN_LOCK_STS = 4'h5,
    FN_LOCK_CLK = 4'h6,
    FN_PWM = 4'h7,
    FN_SIG_DET = 4'h8,
    FN_ALARM = 4'h9,
    FN_TIMER = 4'ha,
    FN_DSP_BUSY = 4'hb
  } pin_fn_e;
  localparam logic [3:0] FN_SRC_BASE = 4'h4;
  localparam logic [3:0] FN_RESET = 4'h1;
  // Debounce sampling period
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DB_TICK_NS = 2048;
  localparam int unsigned DB_TICK_CYC = DB_TICK_NS / CLK_PERIOD_NS;
  localparam logic [15:0] DB_TICK_LAST = 16'(DB_TICK_CYC - 1);
endpackage

/* File: verification/gpio_irq_status_mask_edge_chk.sv */
// Port-level assertions for the GPIO interrupt status, mask and edge block
`timescale 1ns/1ps
module gpio_irq_status_mask_edge_chk
  import gpio_irq_pkg::*;
(
  input wire logic CLK, // Clock
  input wire logic RST_B, // Reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access
  input wire logic PWRITE, // APB write
  input wire logic [gpio_irq_pkg::ADDR_W-1:0] PADDR, // APB address
  input wire logic [31:0] PRDATA, // APB read data
  input wire logic PREADY, // APB ready
  input wire logic PSLVERR, // APB error
  input wire logic [1:0] DSP_IRQ, // DSP lines
  input wire logic EVENT_LOG_FULL, // Log full
  input wire logic IRQ // Interrupt
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  logic setup;
  assign setup = PSEL && !PENABLE;
  a_ready_next: assert property (setup |=> PREADY) else $error("ready late");
  a_ready_single: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0) else $error("rdata leak");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_dsp_line: assert property ((setup && !PWRITE && PADDR == OFF_LINE_STATUS) |=>
    PRDATA[1:0] == $past(DSP_IRQ)) else $error("dsp line status wrong");
  a_full_flag: assert property ((setup && !PWRITE && PADDR == OFF_FULL_STATUS) |=>
    PRDATA == {15'h0, $past(EVENT_LOG_FULL), 16'h0}) else $error("full status wrong");
  a_ro_write_ok: assert property ((setup && PWRITE && PADDR == OFF_FULL_STATUS) |=>
    PREADY && !PSLVERR) else $error("status write refused");
  a_edge_low_zero: assert property ((setup && !PWRITE && PADDR == OFF_EDGE_SEL) |=>
    PRDATA[15:0] == 16'h0) else $error("edge low half set");
  a_mask_unused: assert property ((setup && !PWRITE && PADDR == OFF_MASK) |=>
    PRDATA[15:4] == 12'h0) else $error("unused mask bits set");
  c_err: cover property (PSLVERR);
  c_irq: cover property ($rose(IRQ));
  c_edge_wr: cover property (setup && PWRITE && PADDR == OFF_EDGE_SEL);
endmodule
bind gpio_irq_status_mask_edge gpio_irq_status_mask_edge_chk gpio_irq_status_mask_edge_chk_inst (
  .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DSP_IRQ(DSP_IRQ),
  .EVENT_LOG_FULL(EVENT_LOG_FULL), .IRQ(IRQ));

/* File: verification/gpio_irq_status_mask_edge_tb.sv */
// Self-checking bench for the GPIO interrupt status, mask and edge block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s exp %h got %h", nm, ex, gt); \
    end \
  end
module gpio_irq_status_mask_edge_tb;
  import gpio_irq_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] pin_in = 16'h0;
  logic [7:0] func_src = 8'h0;
  logic [1:0] dsp_irq = 2'h0;
  logic full = 1'b0;
  logic boot = 1'b0;
  logic [15:0] alt_out = 16'h0;
  logic [15:0] alt_oe = 16'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [15:0] pin_out;
  logic [15:0] pin_oe_b;
  logic [7:0] irq_cnt;
  logic [31:0] rd;
  logic [31:0] w;
  logic er;
  logic [2:0] src_sel;
  int n_mismatch = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  gpio_irq_status_mask_edge gpio_irq_status_mask_edge_inst (.CLK(clk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_B(pin_oe_b), .ALT_OUT(alt_out), .ALT_OE(alt_oe),
    .FUNC_SRC(func_src),
    .DSP_IRQ(dsp_irq), .EVENT_LOG_FULL(full), .BOOT_DONE(boot), .IRQ(irq));
  irq_host irq_host_inst (.CLK(clk), .RST_B(rst_b), .IRQ(irq), .SEEN(irq_cnt));
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready ends the wait; only the watchdog ends one where ready never comes
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (12) @(posedge clk);
  endtask
  function automatic logic [31:0] line_exp(logic [15:0] p, logic [1:0] d);
    logic [31:0] e;
    e = {30'h0, d};
    for (int i = 0; i < 8; i++)
      e[16 + 2 * i] = p[i];
    return e;
  endfunction
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
  initial
  begin
    void'($urandom(32'hfbd5));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, OFF_MASK, 32'h0);
    `CHK("mask reset", MASK_RESET & EVT_USED, rd)
    apb(1'b0, OFF_EDGE_SEL, 32'h0);
    `CHK("edge reset", EDGE_SEL_RESET, rd)
    apb(1'b0, 20'h18ffc, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    boot <= 1'b1;
    settle;
    `CHK("boot irq", 1'b1, irq)
    `CHK("host count", 8'h01, irq_cnt)
    apb(1'b0, OFF_EVENT, 32'h0);
    `CHK("boot event", 1'b1, rd[EVT_BOOT])
    apb(1'b1, OFF_EVENT, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("irq after clear", 1'b0, irq)
    // Masked source latches but stays off the line
    dsp_irq <= 2'b01;
    settle;
    `CHK("masked dsp irq", 1'b0, irq)
    apb(1'b1, OFF_MASK, 32'hffff_fffc);
    settle;
    `CHK("unmasked dsp irq", 1'b1, irq)
    apb(1'b0, OFF_MASK, 32'h0);
    `CHK("mask readback", 32'hffff_000c, rd)
    apb(1'b1, OFF_MASK, MASK_RESET);
    settle;
    `CHK("remasked irq", 1'b0, irq)
    for (int k = 0; k < 8; k++)
    begin
      dsp_irq <= 2'($urandom);
      full <= 1'($urandom);
      pin_in <= 16'($urandom);
      func_src <= 8'($urandom);
      settle;
      apb(1'b0, OFF_LINE_STATUS, 32'h0);
      `CHK("line status", line_exp(pin_in, dsp_irq), rd)
      apb(1'b0, OFF_FULL_STATUS, 32'h0);
      `CHK("full status", {15'h0, full, 16'h0}, rd)
    end
    apb(1'b1, OFF_FULL_STATUS, 32'h0);
    `CHK("status write error", 1'b0, er)
    w = $urandom;
    apb(1'b1, OFF_EDGE_SEL, w);
    apb(1'b0, OFF_EDGE_SEL, 32'h0);
    `CHK("edge readback", w & 32'hffff_0000, rd)
    // Edge mode: a steady low pin must not re-set its event
    apb(1'b1, OFF_EDGE_SEL, 32'hffff_0000);
    pin_in <= 16'h0;
    settle;
    apb(1'b1, OFF_EVENT, 32'hffff_ffff);
    settle;
    apb(1'b0, OFF_EVENT, 32'h0);
    `CHK("no pin event", 1'b0, rd[EVT_PIN_LSB])
    pin_in <= 16'h0001;
    settle;
    apb(1'b0, OFF_EVENT, 32'h0);
    `CHK("pin rise event", 1'b1, rd[EVT_PIN_LSB])
    apb(1'b1, OFF_FUNC_LO, 32'h1111_1112);
    settle;
    apb(1'b0, OFF_LINE_STATUS, 32'h0);
    `CHK("non-input level", 1'b0, rd[STS_PIN_LSB])
    // Output functions: dedicated, alternate, GPIO out, irq, source, spare, input
    boot <= 1'b0;
    alt_out <= 16'($urandom);
    alt_oe <= 16'hffff;
    src_sel = 3'($urandom);
    w = {4'h1, 4'hc, 4'(src_sel) + 4'h4, 4'h3, 4'h2, 12'h000};
    apb(1'b1, OFF_FUNC_LO, w);
    apb(1'b0, OFF_FUNC_LO, 32'h0);
    `CHK("function readback", w, rd)
    apb(1'b1, OFF_PIN_CFG, 32'h0000_0008);
    boot <= 1'b1;
    settle;
    `CHK("dedicated pins idle", 2'b11, pin_oe_b[1:0])
    `CHK("alt pin level", alt_out[2], pin_out[2])
    `CHK("alt pin enable", 1'b0, pin_oe_b[2])
    `CHK("gpio out pin", 2'b10, {pin_out[3], pin_oe_b[3]})
    `CHK("irq out pin", 2'b10, {pin_out[4], pin_oe_b[4]})
    `CHK("host count again", 8'h03, irq_cnt)
    `CHK("source out pin", {func_src[src_sel], 1'b0}, {pin_out[5], pin_oe_b[5]})
    `CHK("spare code idle", 1'b1, pin_oe_b[6])
    `CHK("input pin idle", 1'b1, pin_oe_b[7])
    apb(1'b1, OFF_PIN_CFG, 32'h0008_0008);
    settle;
    `CHK("open drain high", 1'b1, pin_oe_b[3])
    apb(1'b1, OFF_PIN_CFG, 32'h0008_0000);
    settle;
    `CHK("open drain low", 2'b00, {pin_out[3], pin_oe_b[3]})
    // Debounced input holds its old level until three equal samples
    apb(1'b1, OFF_DEBOUNCE, 32'h0000_0080);
    pin_in <= 16'h0081;
    settle;
    apb(1'b0, OFF_LINE_STATUS, 32'h0);
    `CHK("debounce hold", 1'b0, rd[STS_PIN_LSB + 14])
    repeat (800) @(posedge clk);
    apb(1'b0, OFF_LINE_STATUS, 32'h0);
    `CHK("debounce accept", 1'b1, rd[STS_PIN_LSB + 14])
    test_done;
  end
endmodule

/* File: verification/irq_host.sv */
// Host-side model that counts interrupt requests it has seen
`timescale 1ns/1ps
module irq_host (
  input wire logic CLK, // System clock
  input wire logic RST_B, // Reset, active low
  input wire logic IRQ, // Interrupt level from the block
  output logic [7:0] SEEN // Count of interrupt assertions
);
  typedef struct packed {
    logic irq_d;
    logic [7:0] seen;
  } host_s;
  host_s st_reg;
  host_s st_next;
  always_comb
  begin
    st_next = st_reg;
    st_next.irq_d = IRQ;
    // Level output: count only the rising moment
    if (IRQ && !st_reg.irq_d)
      st_next.seen = st_reg.seen + 8'h01;
  end
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign SEEN = st_reg.seen;
endmodule
